// file: core/serial_boot_command_interpreter.sv
// Packet-level command interpreter for serial firmware download
//
// How it works
// - Download: opcode 0x21, size 0x0B, address then count, MSB first.
// - Accepted download requests an erase at the download address; its answer waits.
// - Run: opcode 0x22, size 0x07, address MSB first, then jump there.
// - Status query: opcode 0x23, size 0x03, reports last command outcome.
// - Status reply is a framed packet with one status byte.
// - Each data command continues at the address where the last ended.
// - Programming stops once the downloaded byte count is received.
// - A refused data command leaves the programming address unchanged.
// - Reset: opcode 0x25, size 0x03; answer first, then reset.
// - After commanded reset the normal boot sequence runs.
// - Every command packet gets one answer byte, ack or nak.
// - Known opcode, good checksum and well-formed parameters are acknowledged, unless programming fails.
// - Bad checksum or malformed parameters are refused with nak.
// - Status frame size 0x03, checksum of the code in byte one.
// - Code 0x41 for unknown opcode, 0x42 for format error.
// - Codes 0x43 bad address, 0x44 flash failure, 0x45 image check.
// - First byte is total length, counting itself and checksum.
// - Checksum is the eight-bit sum of command and argument bytes.
// - Zero bytes before a packet are skipped; first nonzero is length.
`timescale 1ns/1ps
`include "boot_defs.svh"

module serial_boot_command_interpreter #(
  parameter int          BUF_BYTES = 64,
  parameter logic [31:0] APP_BASE  = 32'h0000_0000,
  parameter logic [31:0] APP_END   = 32'h0010_0000
) (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  // Byte transport, receive side
  input  wire logic        rx_valid,
  input  wire logic [7:0]  rx_data,
  // Byte transport, transmit side
  output logic             tx_valid,
  input  wire logic        tx_ready,
  output logic [7:0]       tx_data,
  // Flash engine
  output logic             erase_req,
  output logic [31:0]      erase_addr,
  output logic             prog_req,
  output logic [31:0]      prog_addr,
  output logic [31:0]      prog_data,
  input  wire logic        flash_done,
  input  wire logic        flash_error,
  // Image check result, sampled when a run is accepted
  input  wire logic        image_check_en,
  input  wire logic        image_check_ok,
  // Hand-off to the rest of the device
  output logic             run_req,
  output logic [31:0]      run_addr,
  output logic             soft_reset_req
);

  typedef struct packed {
    boot_pkg::cmd_state_t        st;
    boot_pkg::post_ack_t         post;
    logic [BUF_BYTES-1:0][7:0]   buffer;
    logic [7:0]                  op;
    logic [7:0]                  len;
    logic                        sum_ok;
    logic                        ovf;
    logic [7:0]                  code;
    logic                        dl_active;
    logic [31:0]                 addr;
    logic [31:0]                 remain;
    logic [7:0]                  count;
    logic [7:0]                  widx;
    logic [7:0]                  tx_byte;
    logic [1:0]                  tx_cnt;
    logic                        erase_req;
    logic [31:0]                 erase_addr;
    logic                        prog_req;
    logic [31:0]                 prog_addr;
    logic [31:0]                 prog_data;
    logic                        run_req;
    logic [31:0]                 run_addr;
    logic                        soft_reset;
  } interp_t;

  interp_t s;
  interp_t next_s;

  logic        listen;
  logic        f_valid;
  logic        pay_valid;
  logic [7:0]  pay_byte;
  logic [7:0]  pay_index;
  logic        pkt_done;
  logic [7:0]  pkt_len;
  logic        pkt_sum_ok;
  logic [7:0]  arg_index;
  logic [31:0] arg_addr;
  logic [31:0] arg_size;
  logic [32:0] dl_end;
  logic [7:0]  byte_base;
  logic [31:0] word;
  logic        last_word;

  // The host is silent while we answer, so bytes are only framed in idle
  assign listen  = (s.st == boot_pkg::ST_IDLE);
  assign f_valid = rx_valid & listen;

  packet_framer_rx u_framer (
    .core_clk   (core_clk),
    .rst_n      (rst_n),
    .rx_valid   (f_valid),
    .rx_data    (rx_data),
    .pay_valid  (pay_valid),
    .pay_byte   (pay_byte),
    .pay_index  (pay_index),
    .pkt_done   (pkt_done),
    .pkt_len    (pkt_len),
    .pkt_sum_ok (pkt_sum_ok)
  );

  assign arg_index = pay_index - 8'h01;

  // Both 32-bit arguments arrive most significant byte first
  assign arg_addr = {s.buffer[0], s.buffer[1], s.buffer[2], s.buffer[3]};
  assign arg_size = {s.buffer[4], s.buffer[5], s.buffer[6], s.buffer[7]};
  assign dl_end   = {1'b0, arg_addr} + {1'b0, arg_size};

  // Flash words are assembled least significant byte first
  assign byte_base = {s.widx[5:0], 2'b00};
  assign last_word = ({1'b0, byte_base} + 9'd4) >= {1'b0, s.count};

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_word
      logic [7:0] pos;
      assign pos = byte_base + 8'(g);
      // A short final word is padded so the unused lanes stay erased
      assign word[8*g +: 8] = (pos < s.count) ? s.buffer[pos]
                                              : `FILL_BYTE;
    end
  endgenerate

  always_comb begin
    next_s            = s;
    next_s.run_req    = 1'b0;
    next_s.soft_reset = 1'b0;

    // Capture the opcode and the argument bytes of the incoming packet
    if (pay_valid) begin
      if (pay_index == 8'h00) begin
        next_s.op  = pay_byte;
        next_s.ovf = 1'b0;
      end else if (32'(arg_index) < BUF_BYTES) begin
        next_s.buffer[arg_index] = pay_byte;
      end else begin
        next_s.ovf = 1'b1;
      end
    end

    case (s.st)
      boot_pkg::ST_IDLE: begin
        if (pkt_done) begin
          next_s.len    = pkt_len;
          next_s.sum_ok = pkt_sum_ok;
          next_s.st     = boot_pkg::ST_DECODE;
        end
      end

      boot_pkg::ST_DECODE: begin
        next_s.post    = boot_pkg::POST_NONE;
        next_s.st      = boot_pkg::ST_NAK;
        next_s.tx_byte = `BYTE_NAK;
        if (!s.sum_ok || s.len < `SIZE_MIN) begin
          // Corrupt frame: refused, status left alone for a resend
        end else if (s.op == `OP_DOWNLOAD) begin
          if (s.len != `SIZE_DOWNLOAD) begin
            next_s.code = `CODE_BAD_FORMAT;
          end else if (arg_addr < APP_BASE || arg_size == 32'h0 ||
                       dl_end > {1'b0, APP_END}) begin
            // Well framed, so answered with ack; the code tells why
            next_s.code      = `CODE_BAD_ADDRESS;
            next_s.dl_active = 1'b0;
            next_s.st        = boot_pkg::ST_ACK;
            next_s.tx_byte   = `BYTE_ACK;
          end else begin
            next_s.addr       = arg_addr;
            next_s.remain     = arg_size;
            next_s.erase_addr = arg_addr;
            next_s.erase_req  = 1'b1;
            next_s.st         = boot_pkg::ST_ERASE;
          end
        end else if (s.op == `OP_RUN) begin
          if (s.len != `SIZE_RUN) begin
            next_s.code = `CODE_BAD_FORMAT;
          end else begin
            next_s.run_addr = arg_addr;
            next_s.post     = boot_pkg::POST_RUN;
            next_s.st       = boot_pkg::ST_ACK;
            next_s.tx_byte  = `BYTE_ACK;
            if (image_check_en && !image_check_ok) begin
              next_s.code = `CODE_IMAGE_CHECK_ERROR;
            end else begin
              next_s.code = `CODE_OK;
            end
          end
        end else if (s.op == `OP_GET_STATUS) begin
          if (s.len != `SIZE_GET_STATUS) begin
            next_s.code = `CODE_BAD_FORMAT;
          end else begin
            // The query itself does not overwrite the reported code
            next_s.post    = boot_pkg::POST_STATUS;
            next_s.st      = boot_pkg::ST_ACK;
            next_s.tx_byte = `BYTE_ACK;
          end
        end else if (s.op == `OP_SEND_DATA) begin
          next_s.count = s.len - `SIZE_HEADER;
          next_s.widx  = 8'h00;
          if (!s.dl_active) begin
            next_s.code = `CODE_BAD_FORMAT;
          end else if (s.ovf || s.len == `SIZE_HEADER ||
                       32'(s.len - `SIZE_HEADER) > s.remain) begin
            next_s.code = `CODE_BAD_FORMAT;
          end else begin
            next_s.st = boot_pkg::ST_PROG;
          end
        end else if (s.op == `OP_RESET) begin
          if (s.len != `SIZE_RESET) begin
            next_s.code = `CODE_BAD_FORMAT;
          end else begin
            next_s.code    = `CODE_OK;
            next_s.post    = boot_pkg::POST_RESET;
            next_s.st      = boot_pkg::ST_ACK;
            next_s.tx_byte = `BYTE_ACK;
          end
        end else begin
          next_s.code = `CODE_UNRECOGNISED_OP;
        end
      end

      boot_pkg::ST_ERASE: begin
        // Acknowledge is held back until the erase has finished
        if (flash_done) begin
          next_s.erase_req = 1'b0;
          next_s.st        = boot_pkg::ST_ACK;
          next_s.tx_byte   = `BYTE_ACK;
          if (flash_error) begin
            next_s.code      = `CODE_PROGRAM_ERROR;
            next_s.dl_active = 1'b0;
          end else begin
            next_s.code      = `CODE_OK;
            next_s.dl_active = 1'b1;
          end
        end
      end

      boot_pkg::ST_PROG: begin
        if (!s.prog_req) begin
          next_s.prog_req  = 1'b1;
          next_s.prog_addr = s.addr + 32'(byte_base);
          next_s.prog_data = word;
        end else if (flash_done) begin
          next_s.prog_req = 1'b0;
          if (flash_error) begin
            // Address not advanced so the host can resend the block
            next_s.code    = `CODE_PROGRAM_ERROR;
            next_s.st      = boot_pkg::ST_NAK;
            next_s.tx_byte = `BYTE_NAK;
          end else if (last_word) begin
            next_s.addr      = s.addr + 32'(s.count);
            next_s.remain    = s.remain - 32'(s.count);
            // Final byte of the image ends the download
            next_s.dl_active = (s.remain != 32'(s.count));
            next_s.code      = `CODE_OK;
            next_s.st        = boot_pkg::ST_ACK;
            next_s.tx_byte   = `BYTE_ACK;
          end else begin
            next_s.widx = s.widx + 8'h01;
          end
        end
      end

      boot_pkg::ST_ACK: begin
        // One answer byte per command packet
        if (tx_ready) begin
          case (s.post)
            boot_pkg::POST_STATUS: begin
              next_s.st      = boot_pkg::ST_STAT;
              next_s.tx_byte = `SIZE_STATUS_PKT;
              next_s.tx_cnt  = 2'd0;
            end
            boot_pkg::POST_RUN: begin
              next_s.st = boot_pkg::ST_RUN;
            end
            boot_pkg::POST_RESET: begin
              next_s.st = boot_pkg::ST_RESET;
            end
            default: begin
              next_s.st = boot_pkg::ST_IDLE;
            end
          endcase
        end
      end

      boot_pkg::ST_NAK: begin
        if (tx_ready) begin
          next_s.st = boot_pkg::ST_IDLE;
        end
      end

      boot_pkg::ST_STAT: begin
        // Size, checksum, code; one code byte so checksum equals it
        if (tx_ready) begin
          next_s.tx_cnt  = s.tx_cnt + 2'd1;
          next_s.tx_byte = s.code;
          if (s.tx_cnt == 2'd2) begin
            next_s.st = boot_pkg::ST_HOST;
          end
        end
      end

      boot_pkg::ST_HOST: begin
        // The host's answer byte is taken here, not framed
        if (rx_valid) begin
          next_s.st = boot_pkg::ST_IDLE;
        end
      end

      boot_pkg::ST_RUN: begin
        next_s.run_req = 1'b1;
        next_s.st      = boot_pkg::ST_IDLE;
      end

      boot_pkg::ST_RESET: begin
        // Acknowledge already sent; the device reset reboots us
        next_s.soft_reset = 1'b1;
        next_s.dl_active  = 1'b0;
        next_s.st         = boot_pkg::ST_IDLE;
      end

      default: begin
        next_s.st = boot_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // Handshake valid is decoded from state; data comes from a flop
  assign tx_valid       = (s.st == boot_pkg::ST_ACK) ||
                          (s.st == boot_pkg::ST_NAK) ||
                          (s.st == boot_pkg::ST_STAT);
  assign tx_data        = s.tx_byte;
  assign erase_req      = s.erase_req;
  assign erase_addr     = s.erase_addr;
  assign prog_req       = s.prog_req;
  assign prog_addr      = s.prog_addr;
  assign prog_data      = s.prog_data;
  assign run_req        = s.run_req;
  assign run_addr       = s.run_addr;
  assign soft_reset_req = s.soft_reset;

endmodule : serial_boot_command_interpreter

// file: core/boot_defs.svh
// Byte values, opcodes, packet sizes and status codes of the boot protocol
`ifndef BOOT_DEFS_SVH
`define BOOT_DEFS_SVH

// Opcodes carried in the first payload byte
`define OP_DOWNLOAD      8'h21
`define OP_RUN           8'h22
`define OP_GET_STATUS    8'h23
`define OP_SEND_DATA     8'h24
`define OP_RESET         8'h25

// Fixed packet sizes, length byte and checksum byte included
`define SIZE_DOWNLOAD    8'h0b
`define SIZE_RUN         8'h07
`define SIZE_GET_STATUS  8'h03
`define SIZE_RESET       8'h03
`define SIZE_STATUS_PKT  8'h03
`define SIZE_MIN         8'h03
`define SIZE_OVERHEAD    8'h02
`define SIZE_HEADER      8'h03

// Single-byte answers
`define BYTE_ACK         8'hcc
`define BYTE_NAK         8'h33

// Status codes
`define CODE_OK                 8'h40
`define CODE_UNRECOGNISED_OP    8'h41
`define CODE_BAD_FORMAT         8'h42
`define CODE_BAD_ADDRESS        8'h43
`define CODE_PROGRAM_ERROR      8'h44
`define CODE_IMAGE_CHECK_ERROR  8'h45

// Filler for the unused bytes of a final partial word (erased flash)
`define FILL_BYTE        8'hff

`endif

// file: core/boot_pkg.sv
// Types shared by the boot command interpreter and its packet framer
package boot_pkg;

  typedef enum logic [1:0] {
    FR_LEN  = 2'b00,
    FR_CHK  = 2'b01,
    FR_DATA = 2'b10
  } framer_state_t;

  typedef enum logic [3:0] {
    ST_IDLE   = 4'b0000,
    ST_DECODE = 4'b0001,
    ST_ERASE  = 4'b0010,
    ST_PROG   = 4'b0011,
    ST_ACK    = 4'b0100,
    ST_NAK    = 4'b0101,
    ST_STAT   = 4'b0110,
    ST_HOST   = 4'b0111,
    ST_RUN    = 4'b1000,
    ST_RESET  = 4'b1001
  } cmd_state_t;

  typedef enum logic [1:0] {
    POST_NONE   = 2'b00,
    POST_STATUS = 2'b01,
    POST_RUN    = 2'b10,
    POST_RESET  = 2'b11
  } post_ack_t;

endpackage : boot_pkg

// file: core/packet_framer_rx.sv
// Receive framer: skips idle zeros, splits length, checksum and payload
`timescale 1ns/1ps
`include "boot_defs.svh"

module packet_framer_rx (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  // Received bytes
  input  wire logic       rx_valid,
  input  wire logic [7:0] rx_data,
  // Payload stream
  output logic            pay_valid,
  output logic [7:0]      pay_byte,
  output logic [7:0]      pay_index,
  // End of packet
  output logic            pkt_done,
  output logic [7:0]      pkt_len,
  output logic            pkt_sum_ok
);

  typedef struct packed {
    boot_pkg::framer_state_t st;
    logic [7:0]              len;
    logic [7:0]              chk;
    logic [7:0]              sum;
    logic [7:0]              left;
    logic [7:0]              idx;
    logic                    pv;
    logic [7:0]              pb;
    logic [7:0]              pi;
    logic                    done;
    logic                    ok;
  } framer_t;

  framer_t s;
  framer_t next_s;
  logic [7:0] sum_now;

  assign sum_now = s.sum + rx_data;

  always_comb begin
    next_s      = s;
    next_s.pv   = 1'b0;
    next_s.done = 1'b0;
    if (rx_valid) begin
      case (s.st)
        boot_pkg::FR_LEN: begin
          // Zeros between packets are line idle, not a length
          if (rx_data != 8'h00) begin
            next_s.len = rx_data;
            next_s.sum = 8'h00;
            next_s.idx = 8'h00;
            if (rx_data == 8'h01) begin
              next_s.done = 1'b1;
              next_s.ok   = 1'b0;
            end else begin
              next_s.st = boot_pkg::FR_CHK;
            end
          end
        end
        boot_pkg::FR_CHK: begin
          next_s.chk  = rx_data;
          next_s.left = s.len - `SIZE_OVERHEAD;
          if (s.len == `SIZE_OVERHEAD) begin
            next_s.done = 1'b1;
            next_s.ok   = 1'b0;
            next_s.st   = boot_pkg::FR_LEN;
          end else begin
            next_s.st = boot_pkg::FR_DATA;
          end
        end
        default: begin
          next_s.pv   = 1'b1;
          next_s.pb   = rx_data;
          next_s.pi   = s.idx;
          next_s.idx  = s.idx + 8'h01;
          next_s.sum  = sum_now;
          next_s.left = s.left - 8'h01;
          if (s.left == 8'h01) begin
            next_s.done = 1'b1;
            next_s.ok   = (sum_now == s.chk);
            next_s.st   = boot_pkg::FR_LEN;
          end
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign pay_valid  = s.pv;
  assign pay_byte   = s.pb;
  assign pay_index  = s.pi;
  assign pkt_done   = s.done;
  assign pkt_len    = s.len;
  assign pkt_sum_ok = s.ok;

endmodule : packet_framer_rx

// file: test/boot_cmd_monitor.sv
// Concurrent checks on the boot command interpreter ports
`timescale 1ns/1ps
`include "boot_defs.svh"

module boot_cmd_monitor (
  // Clock and reset
  input wire logic        core_clk,
  input wire logic        rst_n,
  // Answer bytes
  input wire logic        tx_valid,
  input wire logic        tx_ready,
  input wire logic [7:0]  tx_data,
  // Flash engine
  input wire logic        erase_req,
  input wire logic [31:0] erase_addr,
  input wire logic        prog_req,
  input wire logic [31:0] prog_addr,
  input wire logic [31:0] prog_data,
  input wire logic        flash_done,
  // Hand-off
  input wire logic        run_req,
  input wire logic        soft_reset_req
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  // Last two bytes taken by the host; status codes never equal 0x03
  logic [7:0] h1;
  logic [7:0] h2;
  logic [3:0] since_ack;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      h1 <= 8'h00;
      h2 <= 8'h00;
      since_ack <= 4'hf;
    end else begin
      if (tx_valid && tx_ready) begin
        h1 <= tx_data;
        h2 <= h1;
      end
      if (tx_valid && tx_ready && tx_data == `BYTE_ACK) since_ack <= 4'h0;
      else if (since_ack != 4'hf) since_ack <= since_ack + 4'h1;
    end
  end

  sequence hs;
    tx_valid && tx_ready;
  endsequence
  sequence frame_size;
    hs ##0 tx_data == `SIZE_STATUS_PKT;
  endsequence

  AST_TX_STANDS: assert property (tx_valid && !tx_ready |=>
    tx_valid && $stable(tx_data)) else $error("answer byte dropped");
  AST_ERASE_HELD: assert property (erase_req && !flash_done |=>
    erase_req && $stable(erase_addr)) else $error("erase request dropped");
  AST_PROG_HELD: assert property (prog_req && !flash_done |=>
    prog_req && $stable(prog_addr) && $stable(prog_data))
    else $error("program request dropped");
  AST_ONE_FLASH_OP: assert property (!(erase_req && prog_req))
    else $error("erase and program together");
  AST_FRAME_AFTER_ACK: assert property (frame_size |->
    h1 == `BYTE_ACK) else $error("status frame without ack");
  AST_STATUS_SUM: assert property (hs ##0 h2 == `SIZE_STATUS_PKT |->
    tx_data == h1) else $error("status checksum wrong");
  AST_RUN_AFTER_ACK: assert property (run_req |-> since_ack <= 4'h3)
    else $error("run without ack");
  AST_RUN_PULSE: assert property (run_req |=> !run_req)
    else $error("run pulse too long");
  AST_SRST_AFTER_ACK: assert property (soft_reset_req |->
    since_ack <= 4'h3 && !tx_valid) else $error("reset before ack");
  AST_SRST_PULSE: assert property (soft_reset_req |=>
    !soft_reset_req) else $error("reset pulse too long");
endmodule : boot_cmd_monitor

bind serial_boot_command_interpreter boot_cmd_monitor u_mon (.core_clk,
  .rst_n, .tx_valid, .tx_ready, .tx_data, .erase_req, .erase_addr,
  .prog_req, .prog_addr, .prog_data, .flash_done, .run_req,
  .soft_reset_req);

// file: test/boot_host_model.sv
// Host programmer model: sends framed bytes, takes answers with stalls
`timescale 1ns/1ps

module boot_host_model (
  // Clock
  input  wire logic       core_clk,
  // Bytes towards the device
  output logic            rx_valid,
  output logic [7:0]      rx_data,
  // Bytes from the device
  input  wire logic       tx_valid,
  output logic            tx_ready,
  input  wire logic [7:0] tx_data
);
  initial begin
    rx_valid = 1'b0;
    rx_data = 8'h5a;
    tx_ready = 1'b0;
  end

  // Random ready so answer bytes meet random stalls
  always @(posedge core_clk) #1 tx_ready <= 1'($urandom_range(1));

  task send(input logic [7:0] pkt[$], input int nz);
    for (int i = -nz; i < pkt.size(); i++) begin
      @(posedge core_clk);
      #1;
      rx_valid = 1'b1;
      rx_data = (i < 0) ? 8'h00 : pkt[i];
    end
    @(posedge core_clk);
    #1;
    rx_valid = 1'b0;
    // Released line must not keep showing the last byte
    rx_data = ~rx_data;
  endtask : send

  task recv(output logic [7:0] b);
    b = 8'hxx;
    for (int k = 0; k < 400; k++) begin
      @(posedge core_clk);
      if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
        b = tx_data;
        return;
      end
    end
  endtask : recv
endmodule : boot_host_model

// file: test/serial_boot_command_interpreter_test.sv
// Self-checking bench for the serial boot command interpreter
`timescale 1ns/1ps
`include "boot_defs.svh"

module serial_boot_command_interpreter_test;
  localparam int          BUF  = 8;
  localparam logic [31:0] BASE = 32'h0000_1000;
  localparam logic [31:0] TOP  = 32'h0000_2000;
  logic        core_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        flash_done = 1'b0;
  logic        flash_error = 1'b0;
  logic        fail_next = 1'b0;
  logic        chk_en = 1'b0;
  logic        chk_ok = 1'b0;
  logic        run_seen = 1'b0;
  logic        srst_seen = 1'b0;
  logic        rx_valid, tx_valid, tx_ready, erase_req, prog_req;
  logic        run_req, soft_reset_req;
  logic [7:0]  rx_data, tx_data, b, code;
  logic [31:0] erase_addr, prog_addr, prog_data, run_addr, got_run, pa;
  logic [31:0] last_erase, left;
  logic [63:0] progq[$];
  logic [7:0]  none[$];
  int          num_errors, samples_checked, n_erase;
  bit          active;

  always #2.5 core_clk = ~core_clk;

  serial_boot_command_interpreter #(.BUF_BYTES(BUF), .APP_BASE(BASE),
    .APP_END(TOP)) u_dut (.core_clk, .rst_n, .rx_valid, .rx_data,
    .tx_valid, .tx_ready, .tx_data, .erase_req, .erase_addr, .prog_req,
    .prog_addr, .prog_data, .flash_done, .flash_error,
    .image_check_en(chk_en), .image_check_ok(chk_ok), .run_req,
    .run_addr, .soft_reset_req);
  boot_host_model u_host (.core_clk, .rx_valid, .rx_data, .tx_valid,
    .tx_ready, .tx_data);

  // Flash engine: finishes each request after a random wait
  always @(posedge core_clk) begin
    #1;
    if (flash_done) flash_done = 1'b0;
    else if ((erase_req || prog_req) && $urandom_range(2) == 0) begin
      flash_done = 1'b1;
      flash_error = fail_next;
      fail_next = 1'b0;
      if (prog_req) progq.push_back({prog_addr, prog_data});
      else begin
        n_erase++;
        last_erase = erase_addr;
      end
    end
  end
  always @(posedge core_clk) begin
    if (run_req === 1'b1) begin
      run_seen <= 1'b1;
      got_run <= run_addr;
    end
    if (soft_reset_req === 1'b1) srst_seen <= 1'b1;
  end

  task check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : check

  task test_done;
    if (num_errors == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : test_done

  task cmd(input logic [7:0] op, input logic [7:0] a[$],
           input logic [7:0] bad_sum, input logic [7:0] ans);
    logic [7:0] pkt[$];
    logic [7:0] sum;
    sum = op;
    foreach (a[i]) sum += a[i];
    pkt = {8'(a.size() + 3), sum + bad_sum, op};
    pkt = {pkt, a};
    repeat (2) @(posedge core_clk);
    u_host.send(pkt, $urandom_range(2));
    u_host.recv(b);
    check(b, ans);
  endtask : cmd

  task status(input logic [7:0] exp);
    cmd(`OP_GET_STATUS, none, 8'h00, `BYTE_ACK);
    u_host.recv(b);
    check(b, `SIZE_STATUS_PKT);
    u_host.recv(b);
    check(b, exp);
    u_host.recv(b);
    check(b, exp);
    u_host.send({`BYTE_ACK}, 0);
  endtask : status

  task dl(input logic [31:0] addr, input logic [31:0] cnt);
    bit ok;
    bit fe;
    int ne;
    ok = addr >= BASE && addr + cnt <= TOP && cnt > 0;
    fe = fail_next;
    ne = n_erase;
    cmd(`OP_DOWNLOAD, {addr[31:24], addr[23:16], addr[15:8], addr[7:0],
      cnt[31:24], cnt[23:16], cnt[15:8], cnt[7:0]}, 8'h00, `BYTE_ACK);
    check(n_erase - ne, ok);
    if (ok) check(last_erase, addr);
    // A failed erase leaves no download open
    active = ok && !fe;
    pa = addr;
    left = cnt;
    code = fe ? `CODE_PROGRAM_ERROR : `CODE_OK;
    status(ok ? code : `CODE_BAD_ADDRESS);
  endtask : dl

  // Automatic so the payload queue starts empty on every call
  task automatic data(input int n, input logic fail);
    logic [7:0] d[$];
    logic [31:0] w;
    logic [63:0] e;
    bit bad;
    bad = !active || n > left || n > BUF;
    repeat (n) d.push_back(8'($urandom));
    progq.delete();
    fail_next = fail;
    cmd(`OP_SEND_DATA, d, 8'h00, (bad || fail) ? `BYTE_NAK : `BYTE_ACK);
    if (!bad && !fail) begin
      for (int i = 0; i < n; i += 4) begin
        w = 32'hffff_ffff;
        for (int j = 0; j < 4 && i + j < n; j++) w[8*j +: 8] = d[i + j];
        e = progq.size() > 0 ? progq.pop_front() : 64'hx;
        check(e[63:32], pa);
        check(e[31:0], w);
        pa += 4;
      end
      left -= n;
    end
    code = bad ? `CODE_BAD_FORMAT : fail ? `CODE_PROGRAM_ERROR : `CODE_OK;
    status(code);
  endtask : data

  initial begin
    logic [31:0] seed;
    logic [31:0] ra;
    logic [7:0]  rab[$];
    int          ns[9];
    seed = $urandom(32'h96e13d83);
    ra = $urandom;
    rab = {ra[31:24], ra[23:16], ra[15:8], ra[7:0]};
    ns = '{4, 12, 4, 4, 4, 8, 4, 3, 1};
    repeat (5) @(posedge core_clk);
    #1 rst_n = 1'b1;
    status(8'h00);
    cmd(8'h2f, none, 8'h00, `BYTE_NAK);
    status(`CODE_UNRECOGNISED_OP);
    cmd(`OP_RUN, rab, 8'h01, `BYTE_NAK);
    check(run_seen, 1'b0);
    status(`CODE_UNRECOGNISED_OP);
    cmd(`OP_GET_STATUS, {8'h00}, 8'h00, `BYTE_NAK);
    status(`CODE_BAD_FORMAT);
    // First entry has no download before it; later ones walk the count
    for (int i = 0; i < 9; i++) begin
      if (i == 1) dl(BASE + 4 * $urandom_range(255), 19);
      data(ns[i], i == 3);
    end
    dl(TOP + 4, 4);
    fail_next = 1'b1;
    dl(BASE, 4);
    data(4, 1'b0);
    chk_en = 1'b1;
    cmd(`OP_RUN, rab, 8'h00, `BYTE_ACK);
    repeat (5) @(posedge core_clk);
    check(run_seen, 1'b1);
    check(got_run, ra);
    status(`CODE_IMAGE_CHECK_ERROR);
    cmd(`OP_RESET, none, 8'h00, `BYTE_ACK);
    repeat (5) @(posedge core_clk);
    check(srst_seen, 1'b1);
    // The device answers the reset request by pulling the reset line
    #1 rst_n = 1'b0;
    repeat (2) @(posedge core_clk);
    #1 rst_n = 1'b1;
    status(8'h00);
    test_done;
  end

  initial begin
    #100000;
    num_errors++;
    test_done;
  end
endmodule : serial_boot_command_interpreter_test
